// ==== rtl/burst_sram_pkg.sv ====
// shared constants for the burst sram port
package burst_sram_pkg;

	// configuration widths
	localparam int DATA_W_X8      = 8;
	localparam int DATA_W_X9      = 9;
	localparam int DATA_W_X18     = 18;
	localparam int DATA_W_X36     = 36;
	localparam int ADDR_W_X8_X9   = 21;
	localparam int ADDR_W_X18     = 20;
	localparam int ADDR_W_X36     = 19;
	localparam int DATA_W_DEFAULT = DATA_W_X36;
	localparam int ADDR_W_DEFAULT = ADDR_W_X36;

	// write lane grouping
	localparam int BYTE_LANE_W    = 9;
	localparam int NIBBLE_LANE_W  = 4;
	localparam int NIBBLE_SEL_W   = 2;

	// burst shape
	localparam int            BURST_LEN = 4;
	localparam int            BEAT_W    = 2;
	localparam int            LEFT_W    = 3;
	localparam logic [2:0]    LEFT_FULL = 3'h4;
	localparam logic [2:0]    LEFT_NONE = 3'h0;
	localparam logic [2:0]    LEFT_LAST = 3'h1;
	localparam logic [1:0]    BEAT_ZERO = 2'h0;
	localparam logic [1:0]    BEAT_ONE  = 2'h1;

	// clocking
	localparam int MCLK_PERIOD_PS = 4000;
	localparam int SYNC_STAGES    = 2;

	// burst engine state
	typedef enum logic [0:0] {
		BURST_IDLE = 1'b0,
		BURST_BUSY = 1'b1
	} burst_state_type;

endpackage

// ==== rtl/ddr_burst_sram_port.sv ====
// separate-port four-beat burst sram core sampled by the system clock
`timescale 1ns/1ps

// Operation
// [R1] x8 part: controller drives low-active nibble selects per write beat with the data
// [R2] nibble select bit 0 gates data bits 3:0, bit 1 gates bits 7:4
// [R3] a deasserted nibble select leaves that stored nibble unchanged
// [R4] byte selects sampled with write data; deselected bytes stay unaltered
// [R5] byte select n gates the nth 9-bit data lane
// [R6] data of a deselected byte is discarded, never written
// [R7] one shared address bus, sampled only on true input strobe rises
// [R8] address width 21, 20 or 19 bits by configuration; each location holds four words
// [R9] address ignored on an edge where no port is selected
// [R10] read data driven on output strobe rises, or input strobe rises in single clock mode
// [R11] read select low on a true input strobe rise starts a read
// [R12] each accepted read returns four sequential words, one per output edge
// [R13] a read burst in progress completes after the read select is released
// [R14] read data tri-states after the next true output rise with no read active
// [R15] accesses start only on true input strobe rises, never complementary ones
// [R16] inputs captured on rises of both input strobes, so write data is double rate
// [R17] free-running echo clock follows true output strobe, or input strobe in single mode
// [R18] write select low on a true input strobe rise starts a write
// [R19] write data sampled on both input strobes only while a write is active
// [R20] each write takes four words with own masks on the following strobe edges
// [R21] controller keeps both strobe pairs running as complementary pairs
module ddr_burst_sram_port #(
	parameter int DATA_W   = burst_sram_pkg::DATA_W_DEFAULT,
	parameter int ADDR_W   = burst_sram_pkg::ADDR_W_DEFAULT,
	parameter int STORE_AW = burst_sram_pkg::ADDR_W_DEFAULT,
	parameter int BSEL_W   = (DATA_W < burst_sram_pkg::BYTE_LANE_W) ? 1
				: DATA_W / burst_sram_pkg::BYTE_LANE_W
) (
	input  wire logic                     mclk,
	input  wire logic                     resetn,
	input  wire logic                     in_strobe_true,
	input  wire logic                     in_strobe_comp,
	input  wire logic                     out_strobe_true,
	input  wire logic                     out_strobe_inv,
	input  wire logic                     single_clock_mode,
	input  wire logic [ADDR_W-1:0]        address,
	input  wire logic                     read_port_select_n,
	input  wire logic                     write_port_select_n,
	input  wire logic [DATA_W-1:0]        write_bits_in,
	input  wire logic [burst_sram_pkg::NIBBLE_SEL_W-1:0] nibble_write_select_n,
	input  wire logic [BSEL_W-1:0]        byte_write_select_n,
	output logic      [DATA_W-1:0]        read_data_out,
	output logic                          read_data_oe,
	output logic                          echo_clock
);

	localparam int SYNC_W = 4 + 1 + ADDR_W + 2 + DATA_W + burst_sram_pkg::NIBBLE_SEL_W + BSEL_W;
	localparam int MEM_WORDS = (1 << STORE_AW) * burst_sram_pkg::BURST_LEN;

	// lane enable for every data bit from the active-low selects
	function automatic logic [DATA_W-1:0] lane_enable(
		input logic [burst_sram_pkg::NIBBLE_SEL_W-1:0] nib_n,
		input logic [BSEL_W-1:0]                       byt_n
	);
		logic [DATA_W-1:0] en;
		en = '0;
		for (int i = 0; i < DATA_W; i++) begin
			if (DATA_W == burst_sram_pkg::DATA_W_X8)
				en[i] = ~nib_n[(i / burst_sram_pkg::NIBBLE_LANE_W)
					% burst_sram_pkg::NIBBLE_SEL_W]; // R2
			else
				en[i] = ~byt_n[i / burst_sram_pkg::BYTE_LANE_W]; // R5
		end
		return en;
	endfunction

	// word index inside the array: location then beat
	function automatic logic [STORE_AW+1:0] word_index(
		input logic [STORE_AW-1:0] loc,
		input logic [1:0]          beat
	);
		return {loc, beat};
	endfunction

	logic [SYNC_W-1:0]   sync_a;
	logic [SYNC_W-1:0]   sync_b;
	logic [3:0]          strobe_prev;
	logic                k_s;
	logic                kc_s;
	logic                c_s;
	logic                ci_s;
	logic                single_s;
	logic [ADDR_W-1:0]   addr_s;
	logic                rps_n_s;
	logic                wps_n_s;
	logic [DATA_W-1:0]   wdata_s;
	logic [burst_sram_pkg::NIBBLE_SEL_W-1:0] nib_n_s;
	logic [BSEL_W-1:0]   byt_n_s;
	logic                k_rise;
	logic                kc_rise;
	logic                c_rise;
	logic                ci_rise;
	logic                in_edge;
	logic                out_edge;
	logic                out_true_rise;
	logic [DATA_W-1:0]   mem [0:MEM_WORDS-1];
	logic [STORE_AW-1:0] wr_loc;
	logic [1:0]          wr_beat;
	logic [2:0]          wr_left;
	logic [2:0]          next_wr_left;
	logic                wr_fire;
	logic                wr_start;
	logic [STORE_AW-1:0] rd_loc;
	logic [1:0]          rd_beat;
	logic [2:0]          rd_left;
	logic [2:0]          next_rd_left;
	logic                rd_fire;
	logic                rd_start;
	burst_sram_pkg::burst_state_type rd_state;

	// every pin but mclk and resetn crosses two flops; the first stage feeds only the second
	always_ff @(posedge mclk) begin
		sync_a <= {in_strobe_true, in_strobe_comp, out_strobe_true, out_strobe_inv,
			single_clock_mode, address, read_port_select_n, write_port_select_n,
			write_bits_in, nibble_write_select_n, byte_write_select_n};
		sync_b <= sync_a;
	end

	assign {k_s, kc_s, c_s, ci_s, single_s, addr_s, rps_n_s, wps_n_s,
		wdata_s, nib_n_s, byt_n_s} = sync_b;

	// previous strobe levels for edge finding
	always_ff @(posedge mclk) begin
		if (!resetn)
			strobe_prev <= 4'hF;
		else
			strobe_prev <= {k_s, kc_s, c_s, ci_s};
	end

	assign k_rise        = k_s & ~strobe_prev[3];
	assign kc_rise       = kc_s & ~strobe_prev[2];
	assign c_rise        = c_s & ~strobe_prev[1];
	assign ci_rise       = ci_s & ~strobe_prev[0];
	assign in_edge       = k_rise | kc_rise; // R16
	// single mode borrows the input strobes for the output side
	assign out_edge      = single_s ? in_edge : (c_rise | ci_rise); // R10
	assign out_true_rise = single_s ? k_rise : c_rise;

	// write burst: one beat per input strobe rise after the command
	assign wr_fire      = in_edge && (wr_left != burst_sram_pkg::LEFT_NONE); // R19
	assign next_wr_left = wr_fire ? wr_left - burst_sram_pkg::LEFT_LAST : wr_left;
	// a new write may land on the edge that carries the last beat of the previous one
	assign wr_start     = k_rise && !wps_n_s && (next_wr_left == burst_sram_pkg::LEFT_NONE); // R15 R18

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			wr_left <= burst_sram_pkg::LEFT_NONE;
			wr_beat <= burst_sram_pkg::BEAT_ZERO;
			wr_loc  <= '0;
		end else if (wr_start) begin
			wr_left <= burst_sram_pkg::LEFT_FULL; // R20
			wr_beat <= burst_sram_pkg::BEAT_ZERO;
			wr_loc  <= addr_s[STORE_AW-1:0]; // R7 R8
		end else begin
			wr_left <= next_wr_left;
			if (wr_fire)
				wr_beat <= wr_beat + burst_sram_pkg::BEAT_ONE;
		end
	end

	// masked array update; deselected lanes keep their old bits
	always_ff @(posedge mclk) begin
		if (wr_fire)
			mem[word_index(wr_loc, wr_beat)] <=
				(mem[word_index(wr_loc, wr_beat)] & ~lane_enable(nib_n_s, byt_n_s)) |
				(wdata_s & lane_enable(nib_n_s, byt_n_s)); // R1 R3 R4 R6
	end

	// read burst: command on true input rise, beats on output edges
	assign rd_fire      = out_edge && (rd_left != burst_sram_pkg::LEFT_NONE);
	assign next_rd_left = rd_fire ? rd_left - burst_sram_pkg::LEFT_LAST : rd_left;
	assign rd_start     = k_rise && !rps_n_s && (next_rd_left == burst_sram_pkg::LEFT_NONE); // R11 R15

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			rd_left  <= burst_sram_pkg::LEFT_NONE;
			rd_beat  <= burst_sram_pkg::BEAT_ZERO;
			rd_loc   <= '0;
			rd_state <= burst_sram_pkg::BURST_IDLE;
		end else if (rd_start) begin
			rd_left  <= burst_sram_pkg::LEFT_FULL; // R12
			rd_beat  <= burst_sram_pkg::BEAT_ZERO;
			rd_loc   <= addr_s[STORE_AW-1:0]; // R7 R9
			rd_state <= burst_sram_pkg::BURST_BUSY;
		end else begin
			// deselect does not cut a running burst short
			rd_left <= next_rd_left; // R13
			if (rd_fire)
				rd_beat <= rd_beat + burst_sram_pkg::BEAT_ONE;
			unique case (rd_state)
				burst_sram_pkg::BURST_IDLE: rd_state <= burst_sram_pkg::BURST_IDLE;
				burst_sram_pkg::BURST_BUSY: begin
					if (next_rd_left == burst_sram_pkg::LEFT_NONE)
						rd_state <= burst_sram_pkg::BURST_IDLE;
				end
			endcase
		end
	end

	// output register and its enable
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			read_data_out <= '0;
			read_data_oe  <= 1'b0;
		end else if (rd_fire) begin
			read_data_out <= mem[word_index(rd_loc, rd_beat)]; // R10 R12
			read_data_oe  <= 1'b1;
		end else if (out_true_rise && rd_left == burst_sram_pkg::LEFT_NONE) begin
			read_data_oe  <= 1'b0; // R14
		end
	end

	// echo clock tracks the true output strobe, or the true input strobe in single mode; delay matches the data path
	always_ff @(posedge mclk) begin
		if (!resetn)
			echo_clock <= 1'b0;
		else
			echo_clock <= single_s ? k_s : c_s; // R17
	end

	// helper: beats delivered so far; a start on a last-beat edge belongs to the new burst
	logic [2:0] rd_count;
	always_ff @(posedge mclk) begin
		if (!resetn)
			rd_count <= 3'h0;
		else if (rd_start)
			rd_count <= 3'h0;
		else if (rd_fire)
			rd_count <= rd_count + 3'h1;
	end

	// helper: word held before the current write beat
	logic [DATA_W-1:0] wr_old;
	logic [STORE_AW+1:0] wr_idx_q;
	logic [DATA_W-1:0] wr_en_q;
	always_ff @(posedge mclk) begin
		if (wr_fire) begin
			wr_old   <= mem[word_index(wr_loc, wr_beat)];
			wr_idx_q <= word_index(wr_loc, wr_beat);
			wr_en_q  <= lane_enable(nib_n_s, byt_n_s);
		end
	end

	sequence read_accept_seq;
		k_rise && !rps_n_s && rd_left == burst_sram_pkg::LEFT_NONE;
	endsequence

	sequence read_last_beat_seq;
		rd_fire && rd_left == burst_sram_pkg::LEFT_LAST;
	endsequence

	sequence write_accept_seq;
		k_rise && !wps_n_s && wr_left == burst_sram_pkg::LEFT_NONE;
	endsequence

	// true output rise that finds no beat pending
	sequence read_idle_rise_seq;
		out_true_rise && rd_left == burst_sram_pkg::LEFT_NONE;
	endsequence

	// beat of an open write burst not overlapped by a new command
	sequence write_beat_seq;
		wr_fire && !wr_start;
	endsequence

	AST_READ_START: assert property (@(posedge mclk) disable iff (!resetn) // R11
		read_accept_seq |=> rd_left == 3'h4)
		else $error("read select did not start a burst");

	AST_READ_FOUR: assert property (@(posedge mclk) disable iff (!resetn) // R12
		read_last_beat_seq |-> rd_count == 3'h3)
		else $error("read burst did not carry four beats");

	AST_READ_COMPLETES: assert property (@(posedge mclk) disable iff (!resetn) // R13
		(rd_fire && rd_left > 3'h1 && rps_n_s) |=> rd_left == $past(rd_left) - 3'h1)
		else $error("read burst cut short by deselect");

	AST_OE_RELEASE: assert property (@(posedge mclk) disable iff (!resetn) // R14
		read_idle_rise_seq |=> !read_data_oe)
		else $error("read data not released after idle output rise");

	AST_DATA_ON_EDGE: assert property (@(posedge mclk) disable iff (!resetn) // R10
		!out_edge |=> $stable(read_data_out))
		else $error("read data changed off an output edge");

	AST_NO_COMP_START: assert property (@(posedge mclk) disable iff (!resetn) // R15
		(!k_rise && wr_left == 3'h0 && rd_left == 3'h0) |=> wr_left == 3'h0 && rd_left == 3'h0)
		else $error("access began off a true input rise");

	AST_ADDR_IGNORED: assert property (@(posedge mclk) disable iff (!resetn) // R9
		(k_rise && rps_n_s && wps_n_s) |=> $stable(rd_loc) && $stable(wr_loc))
		else $error("address taken with no port selected");

	AST_WRITE_FOUR: assert property (@(posedge mclk) disable iff (!resetn) // R20
		write_accept_seq |=> wr_left == 3'h4 ##1 (wr_left != 3'h0)[*1] ##[0:160] wr_left == 3'h0)
		else $error("write burst did not finish four beats");

	AST_WRITE_MASK: assert property (@(posedge mclk) disable iff (!resetn) // R3
		wr_fire ##1 1'b1 |-> ((mem[wr_idx_q] ^ wr_old) & ~wr_en_q) == '0)
		else $error("deselected lane of write data was stored");

	AST_ECHO: assert property (@(posedge mclk) disable iff (!resetn) // R17
		(c_rise && !single_s) |=> echo_clock)
		else $error("echo clock not following output strobe");

	// bookkeeping guards: all but the oe and echo checks catch a broken counter, state or held location before it shows on the pins
	AST_OE_DRIVE: assert property (@(posedge mclk) disable iff (!resetn) // R10
		rd_fire |=> read_data_oe)
		else $error("read beat issued with output disabled");

	AST_BUSY_STATE: assert property (@(posedge mclk) disable iff (!resetn) // R13
		(rd_state == burst_sram_pkg::BURST_BUSY) == (rd_left != burst_sram_pkg::LEFT_NONE))
		else $error("read state disagrees with beats left");

	AST_ECHO_SINGLE: assert property (@(posedge mclk) disable iff (!resetn) // R17
		single_s |=> echo_clock == $past(k_s))
		else $error("echo clock not following input strobe in single mode");

	AST_WR_LOC_HOLD: assert property (@(posedge mclk) disable iff (!resetn) // R7
		!wr_start |=> $stable(wr_loc))
		else $error("write location moved inside a burst");

	AST_RD_LOC_HOLD: assert property (@(posedge mclk) disable iff (!resetn) // R7
		!rd_start |=> $stable(rd_loc))
		else $error("read location moved inside a burst");

	AST_WRITE_BEAT: assert property (@(posedge mclk) disable iff (!resetn) // R20
		write_beat_seq |=> wr_beat == $past(wr_beat) + 2'h1)
		else $error("write beat index did not advance");

	AST_READ_BEAT: assert property (@(posedge mclk) disable iff (!resetn) // R12
		(rd_fire && !rd_start) |=> rd_beat == $past(rd_beat) + 2'h1)
		else $error("read beat index did not advance");

	AST_NO_IDLE_WRITE: assert property (@(posedge mclk) disable iff (!resetn) // R19
		wr_left == burst_sram_pkg::LEFT_NONE |-> !wr_fire)
		else $error("write data taken with no write active");

endmodule // ddr_burst_sram_port

// ==== test/ddr_burst_sram_port_test.sv ====
// self-checking bench for the burst sram port
`timescale 1ns/1ps
module ddr_burst_sram_port_test;
	localparam logic [143:0] D1 = 144'h123456789ABCDEF0FEDCBA9876543210A5C3;
	logic        mclk, resetn, in_strobe_true, in_strobe_comp, out_strobe_true;
	logic        out_strobe_inv, single_clock_mode, read_port_select_n;
	logic        write_port_select_n, read_data_oe, echo_clock;
	logic [18:0] address;
	logic [35:0] write_bits_in, read_data_out;
	logic [1:0]  nibble_write_select_n;
	logic [3:0]  byte_write_select_n;
	logic [143:0] mem [16];
	int          checks, failures;

	ddr_burst_sram_port #(.DATA_W(burst_sram_pkg::DATA_W_X36), .STORE_AW(4)) i_dut (.mclk,
		.resetn, .in_strobe_true, .in_strobe_comp, .out_strobe_true, .out_strobe_inv,
		.single_clock_mode, .address, .read_port_select_n, .write_port_select_n,
		.write_bits_in, .nibble_write_select_n, .byte_write_select_n, .read_data_out,
		.read_data_oe, .echo_clock);
	sram_ctrl_model i_ctrl (.mclk, .in_strobe_true, .in_strobe_comp, .out_strobe_true,
		.out_strobe_inv, .single_clock_mode, .address, .read_port_select_n,
		.write_port_select_n, .write_bits_in, .nibble_write_select_n,
		.byte_write_select_n, .read_data_out, .read_data_oe);

	// 250 MHz system clock
	initial mclk = 1'b0;
	always #2 mclk = ~mclk;

	task automatic check_word(input string what, input logic [35:0] e, input logic [35:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic check_flag(input string what, input logic e, input logic g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %b seen %b", what, e, g);
		end
	endtask

	// expected store follows the nine-bit lane of each beat's own select
	task automatic wr(input logic [3:0] l, input logic [143:0] d, input logic [15:0] m,
			input logic sel_n);
		i_ctrl.write_burst({15'h0, l}, d, m, sel_n);
		for (int k = 0; k < 144; k++)
			if (!sel_n && !m[(k / 36) * 4 + (k % 36) / 9])
				mem[l][k] = d[k];
	endtask

	task automatic rd(input logic [3:0] l0, input logic [3:0] l1, input int n);
		i_ctrl.read_bursts({15'h0, l0}, {15'h0, l1}, n);
		for (int b = 0; b < 4 * n; b++) begin
			check_word("read beat", mem[b < 4 ? l0 : l1][36*(b%4) +: 36], i_ctrl.rd_q[b]);
			check_flag("oe in burst", 1'b1, i_ctrl.rd_oe[b]);
		end
		if (!single_clock_mode)
			check_flag("oe after burst", 1'b0, i_ctrl.oe_after);
	endtask

	// echo must trail the strobe of the active mode and rise once a period
	task automatic t_echo();
		int  n;
		logic prev;
		if (single_clock_mode)
			@(posedge in_strobe_true);
		else
			@(posedge out_strobe_true);
		repeat (5) @(posedge mclk);
		#1;
		check_flag("echo phase", 1'b1, echo_clock);
		n = 0;
		prev = echo_clock;
		repeat (64) begin
			@(posedge mclk);
			#1;
			n += (echo_clock === 1'b1 && prev === 1'b0);
			prev = echo_clock;
		end
		check_word("echo rises", 36'h8, 36'(n));
	endtask

	// select low only around a complementary rise must not start a read
	task automatic t_comp_only();
		@(posedge in_strobe_true);
		repeat (2) @(posedge mclk);
		i_ctrl.read_port_select_n <= 1'b0;
		@(posedge in_strobe_comp);
		repeat (2) @(posedge mclk);
		i_ctrl.read_port_select_n <= 1'b1;
		repeat (16) @(posedge mclk);
		#1;
		check_flag("oe after comp select", 1'b0, read_data_oe);
	endtask

	task automatic conclude();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// hang guard
	initial begin
		repeat (20000) @(posedge mclk);
		failures++;
		$display("ERROR watchdog expected finish seen hang");
		conclude();
	end

	// main sequence
	initial begin
		resetn = 1'b0;
		checks = 0;
		failures = 0;
		repeat (19) @(posedge mclk);
		#1;
		check_word("data in reset", 36'h0, read_data_out);
		check_flag("oe in reset", 1'b0, read_data_oe);
		@(posedge mclk);
		resetn <= 1'b1;
		repeat (8) @(posedge mclk);
		wr(4'h5, D1, 16'h0, 1'b0);
		rd(4'h5, 4'h5, 1);
		t_echo();
		$display("test full burst done");
		wr(4'h5, ~D1, 16'h5BDE, 1'b0);
		rd(4'h5, 4'h5, 1);
		$display("test byte selects done");
		wr(4'h5, {D1[71:0], D1[143:72]}, 16'h0, 1'b1);
		rd(4'h5, 4'h5, 1);
		t_comp_only();
		$display("test deselected done");
		wr(4'h9, {D1[71:0], ~D1[143:72]}, 16'h0, 1'b0);
		rd(4'h5, 4'h9, 2);
		$display("test back to back done");
		@(posedge mclk);
		i_ctrl.single_clock_mode <= 1'b1;
		repeat (10) @(posedge mclk);
		rd(4'h9, 4'h9, 1);
		t_echo();
		$display("test single clock done");
		conclude();
	end
endmodule // ddr_burst_sram_port_test

// ==== test/sram_ctrl_model.sv ====
// controller model: strobes, commands, write beats and read capture
`timescale 1ns/1ps
module sram_ctrl_model (
	input  wire logic        mclk,
	output logic             in_strobe_true,
	output logic             in_strobe_comp,
	output logic             out_strobe_true,
	output logic             out_strobe_inv,
	output logic             single_clock_mode,
	output logic [18:0]      address,
	output logic             read_port_select_n,
	output logic             write_port_select_n,
	output logic [35:0]      write_bits_in,
	output logic [1:0]       nibble_write_select_n,
	output logic [3:0]       byte_write_select_n,
	input  wire logic [35:0] read_data_out,
	input  wire logic        read_data_oe
);
	logic [35:0] rd_q [8];
	logic        rd_oe [8];
	logic        oe_after;

	// free-running pairs, offset so strobe edges never meet mclk edges
	initial begin
		in_strobe_true = 1'b0;
		#0.5;
		forever #16 in_strobe_true = ~in_strobe_true;
	end
	assign in_strobe_comp = ~in_strobe_true;
	assign #12 out_strobe_true = in_strobe_true;
	assign out_strobe_inv = ~out_strobe_true;

	// idle levels at time zero
	initial begin
		single_clock_mode = 1'b0;
		address = 19'h0;
		read_port_select_n = 1'b1;
		write_port_select_n = 1'b1;
		write_bits_in = 36'h0;
		nibble_write_select_n = 2'h3;
		byte_write_select_n = 4'hF;
	end

	// land two mclk past a strobe rise, mid-way to the next one
	task automatic wait_in(input logic t);
		if (t)
			@(posedge in_strobe_true);
		else
			@(posedge in_strobe_comp);
		repeat (2) @(posedge mclk);
	endtask

	task automatic wait_out();
		if (single_clock_mode)
			@(posedge in_strobe_true or posedge in_strobe_comp);
		else
			@(posedge out_strobe_true or posedge out_strobe_inv);
	endtask

	// command on a true rise, then one beat ahead of each of the next four rises
	task automatic write_burst(input logic [18:0] adr, input logic [143:0] d,
			input logic [15:0] m, input logic sel_n);
		wait_in(1'b0);
		address <= adr;
		write_port_select_n <= sel_n;
		for (int k = 0; k < 5; k++) begin
			wait_in(k % 2 == 0);
			write_port_select_n <= 1'b1;
			address <= ~address; // scrambled, must be ignored
			if (k < 4) begin
				write_bits_in <= d[36*k +: 36];
				byte_write_select_n <= m[4*k +: 4];
				nibble_write_select_n <= m[4*k +: 2];
			end else begin
				write_bits_in <= ~write_bits_in;
				byte_write_select_n <= 4'hF;
			end
		end
	endtask

	// sample each beat just after the following output edge, before it can move
	task automatic read_bursts(input logic [18:0] a0, input logic [18:0] a1, input int n);
		wait_in(1'b0);
		address <= a0;
		read_port_select_n <= 1'b0;
		wait_in(1'b1);
		address <= a1;
		read_port_select_n <= (n == 1);
		wait_out();
		for (int b = 0; b <= 4 * n; b++) begin
			wait_out();
			#5;
			oe_after = read_data_oe;
			if (b < 4 * n) begin
				rd_q[b] = read_data_out;
				rd_oe[b] = read_data_oe;
			end
			if (b == 3) begin
				@(posedge mclk);
				read_port_select_n <= 1'b1;
			end
		end
	endtask
endmodule // sram_ctrl_model
